// ### mpp_top.sv
// multiplexed port pins: latches, direction, pull-ups, control mode and edge requests
`timescale 1ns/10ps
`include "mpp_defs.svh"
module mpp_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // configuration write port
    input wire logic wr_en_i,
    input wire logic [3:0] wr_port_i,
    input wire mpp_pkg::mpp_sel_e wr_sel_i,
    input wire mpp_pkg::mpp_byte_t wr_data_i,
    // configuration and pin read port
    input wire logic [3:0] rd_port_i,
    input wire mpp_pkg::mpp_sel_e rd_sel_i,
    output mpp_pkg::mpp_byte_t rd_data_o,
    // pins: level in, level out, output enable
    input wire logic [`MPP_NPORT-1:0][7:0] pin_in_i,
    output logic [`MPP_NPORT-1:0][7:0] pin_out_o,
    output logic [`MPP_NPORT-1:0][7:0] pin_oe_o,
    output logic [`MPP_NPORT-1:0][7:0] pull_en_o,
    // peripheral side of each control-mode pin
    input wire logic [`MPP_NPORT-1:0][7:0] periph_out_i,
    input wire logic [`MPP_NPORT-1:0][7:0] periph_oe_i,
    output logic [`MPP_NPORT-1:0][7:0] periph_in_o,
    output mpp_pkg::mpp_tmr_s tmr_o,
    output logic [7:0] irq_o
);
    localparam logic [`MPP_NPORT-1:0][7:0] VALID_M = `MPP_VALID_MASK;
    localparam logic [`MPP_NPORT-1:0][7:0] DIR_M = `MPP_DIR_MASK;
    localparam logic [`MPP_NPORT-1:0][7:0] PULL_M = `MPP_PULL_MASK;
    localparam logic [`MPP_NPORT-1:0][7:0] CTRL_M = `MPP_CTRL_MASK;
    localparam logic [`MPP_NPORT-1:0][7:0] OD_M = `MPP_OD_MASK;
    localparam logic [`MPP_NPORT-1:0][7:0] CTRL_RST = `MPP_CTRL_RST;
    localparam logic [3:0][3:0] TPRI_SLOT = `MPP_TPRI_SLOT;
    localparam logic [3:0][2:0] TPRI_BIT = `MPP_TPRI_BIT;
    localparam logic [3:0][3:0] TSEC_SLOT = `MPP_TSEC_SLOT;
    localparam logic [3:0][2:0] TSEC_BIT = `MPP_TSEC_BIT;
    localparam logic [7:0][3:0] IRQ_SLOT = `MPP_IRQ_SLOT;
    localparam logic [7:0][2:0] IRQ_BIT = `MPP_IRQ_BIT;

    mpp_pkg::mpp_cfg_s [`MPP_NPORT-1:0] cfg_r;
    mpp_pkg::mpp_cfg_s [`MPP_NPORT-1:0] cfg_nxt;
    logic [7:0] rise_en_r;
    logic [7:0] rise_en_nxt;
    logic [7:0] fall_en_r;
    logic [7:0] fall_en_nxt;
    logic [`MPP_NPORT-1:0][7:0] sync1_r;
    logic [`MPP_NPORT-1:0][7:0] sync2_r;
    logic [`MPP_NPORT-1:0][7:0] pin_out_r;
    logic [`MPP_NPORT-1:0][7:0] pin_out_nxt;
    logic [`MPP_NPORT-1:0][7:0] pin_oe_r;
    logic [`MPP_NPORT-1:0][7:0] pin_oe_nxt;
    logic [`MPP_NPORT-1:0][7:0] pull_en_r;
    logic [`MPP_NPORT-1:0][7:0] pull_en_nxt;
    logic [`MPP_NPORT-1:0][7:0] periph_in_r;
    logic [`MPP_NPORT-1:0][7:0] periph_in_nxt;
    mpp_pkg::mpp_tmr_s tmr_r;
    mpp_pkg::mpp_tmr_s tmr_nxt;
    mpp_pkg::mpp_byte_t rd_data_r;
    mpp_pkg::mpp_byte_t rd_data_nxt;
    logic [7:0] irq_lvl;

    // configuration writes, masked to the bits each port really has
    always_comb begin
        cfg_nxt = cfg_r;
        rise_en_nxt = rise_en_r;
        fall_en_nxt = fall_en_r;
        if (wr_en_i) begin
            unique case (wr_sel_i)
                mpp_pkg::MPP_SEL_RISE: rise_en_nxt = wr_data_i;
                mpp_pkg::MPP_SEL_FALL: fall_en_nxt = wr_data_i;
                default: begin
                    if (wr_port_i < 4'(`MPP_NPORT)) begin
                        unique case (wr_sel_i)
                            mpp_pkg::MPP_SEL_LATCH:
                                cfg_nxt[wr_port_i].latch = wr_data_i & VALID_M[wr_port_i];
                            // port 13 bit 0 stays output outside control mode: its direction bit is not writable
                            mpp_pkg::MPP_SEL_DIR:
                                cfg_nxt[wr_port_i].dir = wr_data_i & DIR_M[wr_port_i];
                            // pull-up only where fitted; none on port 6, bit 0 only on 12
                            mpp_pkg::MPP_SEL_PULL:
                                cfg_nxt[wr_port_i].pull = wr_data_i & PULL_M[wr_port_i];
                            mpp_pkg::MPP_SEL_CTRL:
                                cfg_nxt[wr_port_i].ctrl = wr_data_i & CTRL_M[wr_port_i];
                            default: ;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int p = 0; p < `MPP_NPORT; p++) begin
                cfg_r[p].latch <= `MPP_LATCH_RST;
                cfg_r[p].dir <= `MPP_DIR_RST & DIR_M[p];
                cfg_r[p].pull <= `MPP_PULL_RST;
                cfg_r[p].ctrl <= CTRL_RST[p];
            end
            rise_en_r <= `MPP_EDGE_RST;
            fall_en_r <= `MPP_EDGE_RST;
        end else if (ce_i) begin
            cfg_r <= cfg_nxt;
            rise_en_r <= rise_en_nxt;
            fall_en_r <= fall_en_nxt;
        end
    end

    // two-stage synchroniser on every pin; only sync2_r is read by logic
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (ce_i) begin
            sync1_r <= pin_in_i;
            sync2_r <= sync1_r;
        end
    end

    // pin drivers: control mode hands the pin to the peripheral
    always_comb begin
        for (int p = 0; p < `MPP_NPORT; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (!VALID_M[p][b]) begin
                    pin_out_nxt[p][b] = 1'b0;
                    pin_oe_nxt[p][b] = 1'b0;
                end else if (cfg_r[p].ctrl[b]) begin
                    // serial clock and resonator pins turn round through periph_oe_i
                    pin_out_nxt[p][b] = periph_out_i[p][b];
                    pin_oe_nxt[p][b] = periph_oe_i[p][b];
                end else if (OD_M[p][b]) begin
                    // open drain: the pad is only ever pulled low
                    pin_out_nxt[p][b] = 1'b0;
                    pin_oe_nxt[p][b] = ~cfg_r[p].dir[b] & ~cfg_r[p].latch[b];
                end else begin
                    pin_out_nxt[p][b] = cfg_r[p].latch[b];
                    pin_oe_nxt[p][b] = ~cfg_r[p].dir[b];
                end
                // a pull-up is only useful on an input in port mode
                pull_en_nxt[p][b] = cfg_r[p].pull[b] & cfg_r[p].dir[b] & ~cfg_r[p].ctrl[b];
                // peripherals see the pin only while it is handed to them
                periph_in_nxt[p][b] = sync2_r[p][b] & cfg_r[p].ctrl[b];
            end
        end
    end

    // timer strobes from primary and secondary timer pins
    always_comb begin
        for (int t = 0; t < 4; t++) begin
            tmr_nxt.cnt_clk[t] = periph_in_nxt[TPRI_SLOT[t]][TPRI_BIT[t]];
            tmr_nxt.cap1[t] = periph_in_nxt[TPRI_SLOT[t]][TPRI_BIT[t]];
            tmr_nxt.cap0[t] = periph_in_nxt[TPRI_SLOT[t]][TPRI_BIT[t]]
                | periph_in_nxt[TSEC_SLOT[t]][TSEC_BIT[t]];
        end
    end

    // read-back; data reads mix latch and live pin by direction
    always_comb begin
        rd_data_nxt = '0;
        unique case (rd_sel_i)
            mpp_pkg::MPP_SEL_RISE: rd_data_nxt = rise_en_r;
            mpp_pkg::MPP_SEL_FALL: rd_data_nxt = fall_en_r;
            default: begin
                if (rd_port_i < 4'(`MPP_NPORT)) begin
                    unique case (rd_sel_i)
                        mpp_pkg::MPP_SEL_LATCH:
                            rd_data_nxt = ((sync2_r[rd_port_i] & cfg_r[rd_port_i].dir)
                                | (cfg_r[rd_port_i].latch & ~cfg_r[rd_port_i].dir))
                                & VALID_M[rd_port_i];
                        mpp_pkg::MPP_SEL_DIR: rd_data_nxt = cfg_r[rd_port_i].dir;
                        mpp_pkg::MPP_SEL_PULL: rd_data_nxt = cfg_r[rd_port_i].pull;
                        mpp_pkg::MPP_SEL_CTRL: rd_data_nxt = cfg_r[rd_port_i].ctrl;
                        default: rd_data_nxt = '0;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_out_r <= '0;
            pin_oe_r <= '0;
            pin_oe_r[`MPP_IDX_P13][0] <= 1'b1;
            pull_en_r <= '0;
            periph_in_r <= '0;
            tmr_r <= '0;
            rd_data_r <= '0;
        end else if (ce_i) begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            pull_en_r <= pull_en_nxt;
            periph_in_r <= periph_in_nxt;
            tmr_r <= tmr_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    // interrupt pins see the pin only in control mode
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            irq_lvl[i] = periph_in_r[IRQ_SLOT[i]][IRQ_BIT[i]];
        end
    end

    // one detector per request
    for (genvar i = 0; i < 8; i++) begin : g_irq
        mpp_edge_det u_edge (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .ce_i(ce_i),
            .lvl_i(irq_lvl[i]),
            .rise_en_i(rise_en_r[i]),
            .fall_en_i(fall_en_r[i]),
            .pulse_o(irq_o[i])
        );
    end

    assign pin_out_o = pin_out_r;
    assign pin_oe_o = pin_oe_r;
    assign pull_en_o = pull_en_r;
    assign periph_in_o = periph_in_r;
    assign tmr_o = tmr_r;
    assign rd_data_o = rd_data_r;

    property p_p0_unused;
        @(posedge clk_i) disable iff (!rst_n_i)
        (pin_oe_o[`MPP_IDX_P0] & ~VALID_M[`MPP_IDX_P0]) == 8'h00;
    endproperty
    a_p0_unused: assert property (p_p0_unused) else $error("port 0 unused bit driven");

    property p_p6_od;
        @(posedge clk_i) disable iff (!rst_n_i)
        (pin_oe_o[`MPP_IDX_P6] & pin_out_o[`MPP_IDX_P6]) == 8'h00
            && pull_en_o[`MPP_IDX_P6] == 8'h00;
    endproperty
    a_p6_od: assert property (p_p6_od) else $error("port 6 drove high or pulled up");

    property p_p8_analog;
        @(posedge clk_i)
        !rst_n_i |=> cfg_r[`MPP_IDX_P8].ctrl == 8'hff;
    endproperty
    a_p8_analog: assert property (p_p8_analog) else $error("port 8 not analog after reset");

    property p_p9_analog;
        @(posedge clk_i)
        !rst_n_i |=> cfg_r[`MPP_IDX_P9].ctrl == 8'h0f;
    endproperty
    a_p9_analog: assert property (p_p9_analog) else $error("port 9 not analog after reset");

    property p_p12_pull;
        @(posedge clk_i) disable iff (!rst_n_i)
        pull_en_o[`MPP_IDX_P12][7:1] == 7'h00;
    endproperty
    a_p12_pull: assert property (p_p12_pull) else $error("port 12 pull-up above bit 0");

    property p_p13_out;
        @(posedge clk_i) disable iff (!rst_n_i)
        !cfg_r[`MPP_IDX_P13].ctrl[0] |=> pin_oe_o[`MPP_IDX_P13][0];
    endproperty
    a_p13_out: assert property (p_p13_out) else $error("port 13 bit 0 not driving");

    property p_port_out;
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && !cfg_r[`MPP_IDX_P4].dir[0]
            |=> pin_oe_o[`MPP_IDX_P4][0]
                && pin_out_o[`MPP_IDX_P4][0] == $past(cfg_r[`MPP_IDX_P4].latch[0]);
    endproperty
    a_port_out: assert property (p_port_out) else $error("port output not from latch");

    property p_ctrl_route;
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && cfg_r[`MPP_IDX_P1].ctrl[2]
            |=> pin_out_o[`MPP_IDX_P1][2] == $past(periph_out_i[`MPP_IDX_P1][2])
                && pin_oe_o[`MPP_IDX_P1][2] == $past(periph_oe_i[`MPP_IDX_P1][2]);
    endproperty
    a_ctrl_route: assert property (p_ctrl_route) else $error("control pin not routed");

    property p_tmr_caps;
        @(posedge clk_i) disable iff (!rst_n_i)
        tmr_o.cap1 == tmr_o.cnt_clk && (tmr_o.cap0 & tmr_o.cnt_clk) == tmr_o.cnt_clk;
    endproperty
    a_tmr_caps: assert property (p_tmr_caps) else $error("timer capture routing wrong");

    // a held clock enable must freeze every pin driver and request
    property p_ce_freeze;
        @(posedge clk_i) disable iff (!rst_n_i)
        !ce_i |=> $stable(pin_out_o) && $stable(pin_oe_o)
            && $stable(pull_en_o) && $stable(irq_o);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("moved while frozen");

    // an input bit must leave its pad undriven
    property p_input_hiz;
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && cfg_r[`MPP_IDX_P4].dir[0]
            |=> !pin_oe_o[`MPP_IDX_P4][0];
    endproperty
    a_input_hiz: assert property (p_input_hiz) else $error("input bit driven");

    // open drain output with a zero latch must sink the pad
    property p_od_sink;
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && !cfg_r[`MPP_IDX_P6].dir[1] && !cfg_r[`MPP_IDX_P6].latch[1]
            |=> pin_oe_o[`MPP_IDX_P6][1] && !pin_out_o[`MPP_IDX_P6][1];
    endproperty
    a_od_sink: assert property (p_od_sink) else $error("port 6 low not sinking");

    // secondary timer pin must never reach count clock or second capture
    property p_tsec_only;
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && periph_in_nxt[`MPP_IDX_P0][1] && !periph_in_nxt[`MPP_IDX_P0][0]
            |=> tmr_o.cap0[0] && !tmr_o.cnt_clk[0] && !tmr_o.cap1[0];
    endproperty
    a_tsec_only: assert property (p_tsec_only) else $error("secondary pin misrouted");

    c_irq: cover property (@(posedge clk_i) disable iff (!rst_n_i) irq_o != 8'h00);
    c_analog_off: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(cfg_r[`MPP_IDX_P8].ctrl[0]));
    c_od_low: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        pin_oe_o[`MPP_IDX_P6] != 8'h00);
    c_ce_hold: cover property (@(posedge clk_i) disable iff (!rst_n_i) !ce_i);
    c_tsec: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        tmr_o.cap0 != tmr_o.cnt_clk);
endmodule // mpp_top

// ### mpp_defs.svh
// constants for the multiplexed port pin block
`ifndef MPP_DEFS_SVH
`define MPP_DEFS_SVH

// number of port slots and slot index of each port
`define MPP_NPORT 11
`define MPP_IDX_P0 0
`define MPP_IDX_P1 1
`define MPP_IDX_P3 2
`define MPP_IDX_P4 3
`define MPP_IDX_P5 4
`define MPP_IDX_P6 5
`define MPP_IDX_P7 6
`define MPP_IDX_P8 7
`define MPP_IDX_P9 8
`define MPP_IDX_P12 9
`define MPP_IDX_P13 10

// implemented bits per slot, listed from slot 10 down to slot 0
`define MPP_VALID_MASK {8'h07, 8'h1f, 8'h0f, 8'hff, 8'h7f, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'hff, 8'h63}
// bits with a settable direction (port 13 bit 0 is output only outside control mode)
`define MPP_DIR_MASK {8'h06, 8'h1f, 8'h0f, 8'hff, 8'h7f, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'hff, 8'h63}
// bits with a pull-up option
`define MPP_PULL_MASK {8'h06, 8'h01, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h0f, 8'h0f, 8'h0f, 8'hff, 8'h63}
// bits with a control mode
`define MPP_CTRL_MASK {8'h07, 8'h1f, 8'h0f, 8'hff, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h0f, 8'hff, 8'h63}
// bits whose port is open drain
`define MPP_OD_MASK {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}

// reset values
`define MPP_LATCH_RST 8'h00
`define MPP_DIR_RST 8'hff
`define MPP_PULL_RST 8'h00
// analog ports come up in control mode
`define MPP_CTRL_RST {8'h00, 8'h00, 8'h0f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}
`define MPP_EDGE_RST 8'h00

// timer pins, timer 3 down to timer 0: slot and bit
`define MPP_TPRI_SLOT {4'd10, 4'd2, 4'd0, 4'd0}
`define MPP_TPRI_BIT {3'd1, 3'd1, 3'd5, 3'd0}
`define MPP_TSEC_SLOT {4'd10, 4'd2, 4'd0, 4'd0}
`define MPP_TSEC_BIT {3'd2, 3'd2, 3'd6, 3'd1}

// external interrupt pins, request 7 down to 0: slot and bit
`define MPP_IRQ_SLOT {4'd6, 4'd6, 4'd1, 4'd2, 4'd2, 4'd2, 4'd2, 4'd9}
`define MPP_IRQ_BIT {3'd3, 3'd2, 3'd6, 3'd3, 3'd2, 3'd1, 3'd0, 3'd0}

`endif

// ### mpp_pkg.sv
// types shared by the multiplexed port pin block
package mpp_pkg;
    typedef logic [7:0] mpp_byte_t;

    // configuration of one port
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] pull;
        logic [7:0] ctrl;
    } mpp_cfg_s;

    // configuration access selector
    typedef enum logic [2:0] {
        MPP_SEL_LATCH = 3'h0,
        MPP_SEL_DIR = 3'h1,
        MPP_SEL_PULL = 3'h2,
        MPP_SEL_CTRL = 3'h3,
        MPP_SEL_RISE = 3'h4,
        MPP_SEL_FALL = 3'h5
    } mpp_sel_e;

    // 16-bit timer input strobes, one bit per timer
    typedef struct packed {
        logic [3:0] cnt_clk;
        logic [3:0] cap0;
        logic [3:0] cap1;
    } mpp_tmr_s;
endpackage

// ### mpp_edge_det.sv
// valid-edge detector for one external interrupt request
`timescale 1ns/10ps
module mpp_edge_det (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic lvl_i,
    input wire logic rise_en_i,
    input wire logic fall_en_i,
    output logic pulse_o
);
    logic prev_r;
    logic prev_nxt;
    logic pulse_r;
    logic pulse_nxt;

    // both enables set gives both edges; none set disables the request
    always_comb begin
        prev_nxt = lvl_i;
        pulse_nxt = (rise_en_i & lvl_i & ~prev_r) | (fall_en_i & ~lvl_i & prev_r);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_r <= 1'b0;
            pulse_r <= 1'b0;
        end else if (ce_i) begin
            prev_r <= prev_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign pulse_o = pulse_r;

    property p_rise_edge;
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && rise_en_i && lvl_i && !prev_r |=> pulse_o;
    endproperty
    a_rise_edge: assert property (p_rise_edge) else $error("rising edge missed");

    property p_no_edge;
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && (lvl_i == prev_r) |=> !pulse_o;
    endproperty
    a_no_edge: assert property (p_no_edge) else $error("request without edge");

    property p_fall_off;
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && !fall_en_i && !lvl_i && prev_r |=> !pulse_o;
    endproperty
    a_fall_off: assert property (p_fall_off) else $error("disabled falling edge fired");
endmodule // mpp_edge_det

// ### mpp_board.sv
// board model: pin wire resolution, external drivers and clock source
`timescale 1ns/10ps
module mpp_board (
    input wire logic clk_i,
    input wire logic [10:0][7:0] pin_out_i,
    input wire logic [10:0][7:0] pin_oe_i,
    input wire logic [10:0][7:0] pull_en_i,
    input wire logic [10:0][7:0] drv_i,
    input wire logic [10:0][7:0] drv_en_i,
    input wire logic xclk_en_i,
    output logic [10:0][7:0] pin_o
);
    logic [10:0][7:0] last_r;
    logic xclk_r = 1'b0;

    // floating pins show the inverse of their last level, never a stale copy
    always_comb begin
        for (int s = 0; s < 11; s++) begin
            for (int b = 0; b < 8; b++) begin
                if (pin_oe_i[s][b]) begin
                    pin_o[s][b] = pin_out_i[s][b];
                end else if (drv_en_i[s][b]) begin
                    pin_o[s][b] = drv_i[s][b];
                end else if (pull_en_i[s][b]) begin
                    pin_o[s][b] = 1'b1;
                end else begin
                    pin_o[s][b] = ~last_r[s][b];
                end
            end
        end
        // external clock: true level on pin a, inverse on pin b
        if (xclk_en_i) begin
            pin_o[9][1] = xclk_r;
            pin_o[9][2] = ~xclk_r;
        end
    end

    // history of each wire and a free clock source, stopped while disabled
    always @(posedge clk_i) begin
        last_r <= pin_o;
        xclk_r <= xclk_en_i ? ~xclk_r : 1'b0;
    end
endmodule // mpp_board

// ### mpp_top_tb.sv
// self-checking testbench for the multiplexed port pin block
`timescale 1ns/10ps
module mpp_top_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en = 1'b0;
    logic [3:0] wr_port = 4'h0;
    logic [3:0] rd_port = 4'h0;
    mpp_pkg::mpp_sel_e wr_sel = mpp_pkg::MPP_SEL_LATCH;
    mpp_pkg::mpp_sel_e rd_sel = mpp_pkg::MPP_SEL_LATCH;
    mpp_pkg::mpp_byte_t wr_data = 8'h00;
    mpp_pkg::mpp_byte_t rd_data;
    logic [10:0][7:0] pin_in, pin_out, pin_oe, pull_en, p_in;
    logic [10:0][7:0] p_out = '0, p_oe = '0, drv = '0, drv_en = '0;
    mpp_pkg::mpp_tmr_s tmr;
    logic [7:0] irq;
    logic xclk_en = 1'b0;
    logic ce = 1'b1;
    int failures = 0;
    int checks_done = 0;
    int irq_cnt = 0;
    int c0;
    // expected per-slot bits: implemented, settable direction, pull-up, reset control
    localparam logic [7:0] val_m [0:10] = '{8'h63, 8'hff, 8'h0f, 8'h0f, 8'h0f, 8'h0f,
        8'h7f, 8'hff, 8'h0f, 8'h1f, 8'h07};
    localparam logic [7:0] dir_m [0:10] = '{8'h63, 8'hff, 8'h0f, 8'h0f, 8'h0f, 8'h0f,
        8'h7f, 8'hff, 8'h0f, 8'h1f, 8'h06};
    localparam logic [7:0] pul_m [0:10] = '{8'h63, 8'hff, 8'h0f, 8'h0f, 8'h0f, 8'h00,
        8'h7f, 8'h00, 8'h00, 8'h01, 8'h06};
    localparam logic [7:0] ctl_r [0:10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hff, 8'h0f, 8'h00, 8'h00};
    localparam logic [1:0] modes [0:2] = '{2'b10, 2'b01, 2'b11};

    always #2.5 clk = ~clk;

    mpp_top mpp_top_i (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .wr_en_i(wr_en),
        .wr_port_i(wr_port), .wr_sel_i(wr_sel), .wr_data_i(wr_data), .rd_port_i(rd_port),
        .rd_sel_i(rd_sel), .rd_data_o(rd_data), .pin_in_i(pin_in), .pin_out_o(pin_out),
        .pin_oe_o(pin_oe), .pull_en_o(pull_en), .periph_out_i(p_out), .periph_oe_i(p_oe),
        .periph_in_o(p_in), .tmr_o(tmr), .irq_o(irq));

    mpp_board mpp_board_i (.clk_i(clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
        .pull_en_i(pull_en), .drv_i(drv), .drv_en_i(drv_en), .xclk_en_i(xclk_en),
        .pin_o(pin_in));

    // counts cycles with request 0 high, so a stretched pulse shows as extra
    always @(posedge clk) begin
        if (irq[0] === 1'b1) irq_cnt++;
    end

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one-cycle write strobe; sel 0 latch 1 dir 2 pull 3 ctrl 4 rise 5 fall
    task automatic wr(input logic [3:0] p, input logic [2:0] s, input logic [7:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        wr_port = p;
        wr_sel = mpp_pkg::mpp_sel_e'(s);
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
    endtask

    // read data is registered on the same edge that samples the address
    task automatic rd(input logic [3:0] p, input logic [2:0] s, input logic [7:0] e,
        input string what);
        @(negedge clk);
        rd_port = p;
        rd_sel = mpp_pkg::mpp_sel_e'(s);
        @(negedge clk);
        chk(what, e, rd_data);
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #50000;
        failures++;
        conclude();
    end

    initial begin
        cyc(6);
        rst_n = 1'b1;
        chk("p13 oe at reset", 8'h01, pin_oe[10]);
        for (int s = 0; s < 11; s++) begin
            rd(s, 3'h1, dir_m[s], "reset dir");
            rd(s, 3'h3, ctl_r[s], "reset ctrl");
            wr(s, 3'h2, 8'hff);
            rd(s, 3'h2, pul_m[s], "pull bits");
            wr(s, 3'h1, 8'h00);
            wr(s, 3'h0, 8'hff);
            rd(s, 3'h0, val_m[s], "latch bits");
            wr(s, 3'h2, 8'h00);
            wr(s, 3'h0, 8'h00);
        end
        $display("test port widths done");
        // plain port: output from latch, input reads the wire, pull-up on inputs
        wr(3, 3'h0, 8'h0a);
        cyc(1);
        chk("p4 out", 8'h0a, pin_out[3]);
        chk("p4 oe", 8'h0f, pin_oe[3]);
        wr(3, 3'h1, 8'h0f);
        wr(3, 3'h2, 8'h0f);
        drv[3] = 8'h05;
        drv_en[3] = 8'h0f;
        cyc(3);
        rd(3, 3'h0, 8'h05, "p4 input level");
        chk("p4 pull", 8'h0f, pull_en[3]);
        wr(5, 3'h0, 8'h05);
        cyc(1);
        chk("p6 oe", 8'h0a, pin_oe[5]);
        chk("p6 out", 8'h00, pin_out[5]);
        // clock enable low: the write is refused and the pins hold
        ce = 1'b0;
        wr(3, 3'h1, 8'h00);
        cyc(2);
        chk("p4 oe frozen", 8'h00, pin_oe[3]);
        ce = 1'b1;
        rd(3, 3'h1, 8'h0f, "p4 dir kept");
        $display("test port mode done");
        // control mode hands the pins to the peripheral, bit by bit
        p_out[1] = 8'h5a;
        p_oe[1] = 8'hfe;
        drv[1] = 8'h01;
        drv_en[1] = 8'h01;
        wr(1, 3'h3, 8'hff);
        cyc(4);
        chk("p1 ctrl out", 8'h5a, pin_out[1]);
        chk("p1 ctrl oe", 8'hfe, pin_oe[1]);
        chk("p1 serial clock in", 8'h5b, p_in[1]);
        wr(1, 3'h3, 8'hfe);
        cyc(4);
        chk("p1 bit0 port oe", 8'hff, pin_oe[1]);
        chk("p1 bit0 periph in", 8'h5a, p_in[1]);
        wr(7, 3'h3, 8'h00);
        rd(7, 3'h3, 8'h00, "p8 analog off");
        p_out[6] = 8'h01;
        p_oe[6] = 8'h01;
        wr(6, 3'h3, 8'h7f);
        cyc(1);
        chk("p7 can tx oe", 8'h01, pin_oe[6]);
        $display("test control mode done");
        // timer pins: primary feeds count and both captures, secondary first only
        wr(0, 3'h3, 8'h63);
        drv_en[0] = 8'h63;
        drv[0] = 8'h01;
        cyc(4);
        chk("timer0 primary", 12'h111, tmr);
        drv[0] = 8'h02;
        cyc(4);
        chk("timer0 secondary", 12'h010, tmr);
        drv[0] = 8'h20;
        cyc(4);
        chk("timer1 primary", 12'h222, tmr);
        chk("p0 periph in", 8'h20, p_in[0]);
        $display("test timer pins done");
        // request 0 on port 12 bit 0 in each edge mode
        wr(9, 3'h3, 8'h07);
        drv_en[9] = 8'h01;
        drv[9] = 8'h00;
        for (int m = 0; m < 3; m++) begin
            wr(0, 3'h4, {7'h00, modes[m][1]});
            wr(0, 3'h5, {7'h00, modes[m][0]});
            rd(0, 3'h4, {7'h00, modes[m][1]}, "rise enables");
            rd(0, 3'h5, {7'h00, modes[m][0]}, "fall enables");
            cyc(6);
            c0 = irq_cnt;
            drv[9] = 8'h01;
            cyc(8);
            chk("irq on rise", modes[m][1], irq_cnt - c0);
            c0 = irq_cnt;
            drv[9] = 8'h00;
            cyc(8);
            chk("irq on fall", modes[m][0], irq_cnt - c0);
        end
        $display("test edge requests done");
        xclk_en = 1'b1;
        cyc(5);
        chk("resonator pair", 8'h01, p_in[9][1] ^ p_in[9][2]);
        xclk_en = 1'b0;
        $display("test clock pins done");
        conclude();
    end
endmodule // mpp_top_tb
